// ===== rtl/ifrs_pkg.sv
/*
  ifrs_pkg: register offsets, bit positions, write masks and reset values
  of the interrupt flag, enable and reset status block.
  assumes: an 8-bit register port on a single 10 MHz system clock.
*/
package ifrs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CORE_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERI_EN1  = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_PERI_EN2  = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_PERI_FL1  = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_PERI_FL2  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PWR_STAT  = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_PIN_CHG   = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_BOR_CTRL  = 8'h07;

  // ----------------------------------------------------------------
  // core control bit positions
  // ----------------------------------------------------------------
  localparam int B_GLOBAL_EN  = 7;
  localparam int B_PERI_EN    = 6;
  localparam int B_T0_EN      = 5;
  localparam int B_EXT_EN     = 4;
  localparam int B_PCHG_EN    = 3;
  localparam int B_T0_FLAG    = 2;
  localparam int B_EXT_FLAG   = 1;
  localparam int B_PCHG_FLAG  = 0;

  // ----------------------------------------------------------------
  // peripheral group one / two bit positions (enable and flag alike)
  // ----------------------------------------------------------------
  localparam int B_T1_GATE    = 7;
  localparam int B_ADC        = 6;
  localparam int B_LIM2       = 3;
  localparam int B_LIM1       = 2;
  localparam int B_T2         = 1;
  localparam int B_T1         = 0;
  localparam int B_CMP2       = 5;
  localparam int B_CMP1       = 4;
  localparam int B_COG        = 2;
  localparam int B_CCP        = 0;

  // ----------------------------------------------------------------
  // power status bit positions
  // ----------------------------------------------------------------
  localparam int B_POR        = 1;
  localparam int B_BOR        = 0;

  // ----------------------------------------------------------------
  // implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MASK_CORE   = 8'hff;
  localparam logic [DATA_W-1:0] MASK_PERI1  = 8'hcf;
  localparam logic [DATA_W-1:0] MASK_PERI2  = 8'h35;
  localparam logic [DATA_W-1:0] MASK_PWR    = 8'h03;
  localparam logic [DATA_W-1:0] RST_CORE    = 8'h00;
  localparam logic [DATA_W-1:0] RST_PERI    = 8'h00;
  localparam logic [DATA_W-1:0] RST_PWR     = 8'h01;
  localparam logic [DATA_W-1:0] RST_PIN_CHG = 8'h00;
  localparam logic              RST_BOR_EN  = 1'b0;

endpackage

// ===== rtl/ifrs_top.sv
/*
  ifrs_top: interrupt enable and flag registers, combined cpu interrupt
  request, and power-on / brown-out reset status.
  assumes: all event inputs are synchronous to sys_clk and are either
  one-cycle pulses or levels (ext pin, pin-change pins, comparator outputs, pwm mode); the register master
  never asserts both strobes at once.
*/
// Functional notes
// R1: flags set regardless of any enable bit
// R2: software clears stale flags before enabling
// R3: global enable bit 7 gates every interrupt
// R4: peripheral group enable bit 6 gates peripherals
// R5: timer-0 rollover sets bit 2 until cleared
// R6: reset never touches the timer-0 counter
// R7: chosen pin edge sets bit 1 flag
// R8: enabled pin change sets bit 0 flag
// R9: peripheral enable one map, bits 5-4 zero
// R10: peripheral enable two map, unused bits zero
// R11: adc completion sets flag bit 6
// R12: timer-1 gate event sets flag bit 7
// R13: limit timer matches set bits 3 and 2
// R14: timer-2 period match sets bit 1
// R15: timer-1 rollover sets bit 0
// R16: comparator output change sets bits 5/4
// R17: output generator shutdown sets bit 2
// R18: capture/compare sets bit 0, not in pwm
// R19: power-on status reads 0 after power-on
// R20: brown-out status reads 0 after brown-out
// R21: power register holds brown-out enable, upper zero; the code keeps the enable in its own register at 0x07, bit 0
// R22: request when flag, enable and global set
module ifrs_top #(
  parameter int PIN_CNT = 6
) (
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  input  wire logic [ifrs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ifrs_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output logic      [ifrs_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                         timer_zero_rollover,
  input  wire logic                         ext_irq_pin,
  input  wire logic                         ext_edge_rising,
  input  wire logic [PIN_CNT-1:0]           pin_change_pins,
  input  wire logic                         timer_one_gate_event,
  input  wire logic                         adc_done_event,
  input  wire logic                         limit_timer_one_match,
  input  wire logic                         limit_timer_two_match,
  input  wire logic                         timer_two_match,
  input  wire logic                         timer_one_rollover,
  input  wire logic                         comparator_one_output,
  input  wire logic                         comparator_two_output,
  input  wire logic                         output_generator_shutdown,
  input  wire logic                         capture_compare_event,
  input  wire logic                         capture_compare_pwm_mode,
  input  wire logic                         brownout_reset_event,
  output logic                              cpu_irq,
  output logic                              brownout_enable
);
  import ifrs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register access helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [DATA_W-1:0] upd(input logic [DATA_W-1:0] cur,
                                            input logic                we,
                                            input logic [DATA_W-1:0] wd,
                                            input logic [DATA_W-1:0] set,
                                            input logic [DATA_W-1:0] msk);
    upd = ((we ? wd : cur) | set) & msk;
  endfunction

  // ----------------------------------------------------------------
  // edge detection of level inputs
  // ----------------------------------------------------------------
  logic               primed_reg;
  logic               ext_prev_reg;
  logic               cmp1_prev_reg;
  logic               cmp2_prev_reg;
  logic [PIN_CNT-1:0] pins_prev_reg;
  logic [PIN_CNT-1:0] pin_chg_en_reg;
  logic               ext_edge;
  logic               pin_chg;
  logic               cmp1_chg;
  logic               cmp2_chg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_reg    <= 1'b0;
      ext_prev_reg  <= 1'b0;
      cmp1_prev_reg <= 1'b0;
      cmp2_prev_reg <= 1'b0;
      pins_prev_reg <= '0;
    end else begin
      primed_reg    <= 1'b1;
      ext_prev_reg  <= ext_irq_pin;
      cmp1_prev_reg <= comparator_one_output;
      cmp2_prev_reg <= comparator_two_output;
      pins_prev_reg <= pin_change_pins;
    end
  end

  // the first cycle after reset only loads history, so no false edges
  assign ext_edge = primed_reg && (ext_edge_rising ? (ext_irq_pin && !ext_prev_reg)
                                                   : (!ext_irq_pin && ext_prev_reg)); // R7
  assign pin_chg  = primed_reg && |((pin_change_pins ^ pins_prev_reg) & pin_chg_en_reg); // R8
  assign cmp1_chg = primed_reg && (comparator_one_output != cmp1_prev_reg); // R16
  assign cmp2_chg = primed_reg && (comparator_two_output != cmp2_prev_reg); // R16

  // ----------------------------------------------------------------
  // hardware set vectors
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] core_set;
  logic [DATA_W-1:0] peri1_set;
  logic [DATA_W-1:0] peri2_set;

  always_comb begin
    core_set               = '0;
    core_set[B_T0_FLAG]    = timer_zero_rollover; // R5
    core_set[B_EXT_FLAG]   = ext_edge; // R7
    core_set[B_PCHG_FLAG]  = pin_chg; // R8
    peri1_set              = '0;
    peri1_set[B_T1_GATE]   = timer_one_gate_event; // R12
    peri1_set[B_ADC]       = adc_done_event; // R11
    peri1_set[B_LIM2]      = limit_timer_two_match; // R13
    peri1_set[B_LIM1]      = limit_timer_one_match; // R13
    peri1_set[B_T2]        = timer_two_match; // R14
    peri1_set[B_T1]        = timer_one_rollover; // R15
    peri2_set              = '0;
    peri2_set[B_CMP2]      = cmp2_chg; // R16
    peri2_set[B_CMP1]      = cmp1_chg; // R16
    peri2_set[B_COG]       = output_generator_shutdown; // R17
    peri2_set[B_CCP]       = capture_compare_event && !capture_compare_pwm_mode; // R18
  end

  // ----------------------------------------------------------------
  // interrupt registers (hardware set wins over a software clear)
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] core_reg;
  logic [DATA_W-1:0] peri_en1_reg;
  logic [DATA_W-1:0] peri_en2_reg;
  logic [DATA_W-1:0] peri_fl1_reg;
  logic [DATA_W-1:0] peri_fl2_reg;

  // timer-0 counter lives outside and is not reset here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= RST_CORE; // R6
    end else begin
      core_reg <= upd(core_reg, wr_stb && hit(addr, OFF_CORE_CTRL), wr_data,
                      core_set, MASK_CORE); // R1
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      peri_en1_reg <= RST_PERI;
      peri_en2_reg <= RST_PERI;
    end else begin
      peri_en1_reg <= upd(peri_en1_reg, wr_stb && hit(addr, OFF_PERI_EN1), wr_data,
                          '0, MASK_PERI1); // R9
      peri_en2_reg <= upd(peri_en2_reg, wr_stb && hit(addr, OFF_PERI_EN2), wr_data,
                          '0, MASK_PERI2); // R10
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      peri_fl1_reg <= RST_PERI;
      peri_fl2_reg <= RST_PERI;
    end else begin
      peri_fl1_reg <= upd(peri_fl1_reg, wr_stb && hit(addr, OFF_PERI_FL1), wr_data,
                          peri1_set, MASK_PERI1); // R1
      peri_fl2_reg <= upd(peri_fl2_reg, wr_stb && hit(addr, OFF_PERI_FL2), wr_data,
                          peri2_set, MASK_PERI2); // R1
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_chg_en_reg <= RST_PIN_CHG[PIN_CNT-1:0];
    end else if (wr_stb && hit(addr, OFF_PIN_CHG)) begin
      pin_chg_en_reg <= wr_data[PIN_CNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // power status and brown-out enable
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] pwr_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= RST_PWR; // R19
    end else if (brownout_reset_event) begin
      pwr_reg[B_BOR] <= 1'b0; // R20
    end else if (wr_stb && hit(addr, OFF_PWR_STAT)) begin
      pwr_reg <= wr_data & MASK_PWR; // R21
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_enable <= RST_BOR_EN;
    end else if (wr_stb && hit(addr, OFF_BOR_CTRL)) begin
      brownout_enable <= wr_data[0]; // R21
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic core_pend;
  logic peri_pend;
  logic irq_cond;

  assign core_pend = (core_reg[B_T0_EN]   && core_reg[B_T0_FLAG])
                  || (core_reg[B_EXT_EN]  && core_reg[B_EXT_FLAG])
                  || (core_reg[B_PCHG_EN] && core_reg[B_PCHG_FLAG]);
  assign peri_pend = core_reg[B_PERI_EN]
                  && (|(peri_en1_reg & peri_fl1_reg) || |(peri_en2_reg & peri_fl2_reg)); // R4
  assign irq_cond  = core_reg[B_GLOBAL_EN] && (core_pend || peri_pend); // R3

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= irq_cond; // R22
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (!rd_stb) begin
      rd_data <= '0;
    end else if (hit(addr, OFF_CORE_CTRL)) begin
      rd_data <= core_reg;
    end else if (hit(addr, OFF_PERI_EN1)) begin
      rd_data <= peri_en1_reg;
    end else if (hit(addr, OFF_PERI_EN2)) begin
      rd_data <= peri_en2_reg;
    end else if (hit(addr, OFF_PERI_FL1)) begin
      rd_data <= peri_fl1_reg;
    end else if (hit(addr, OFF_PERI_FL2)) begin
      rd_data <= peri_fl2_reg;
    end else if (hit(addr, OFF_PWR_STAT)) begin
      rd_data <= pwr_reg;
    end else if (hit(addr, OFF_PIN_CHG)) begin
      rd_data <= DATA_W'(pin_chg_en_reg);
    end else if (hit(addr, OFF_BOR_CTRL)) begin
      rd_data <= {{(DATA_W-1){1'b0}}, brownout_enable};
    end else begin
      rd_data <= '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_flag_any_enable;
    (timer_zero_rollover && !core_reg[B_T0_EN] && !core_reg[B_GLOBAL_EN])
      |=> core_reg[B_T0_FLAG];
  endproperty
  a_flag_any_enable: assert property (p_flag_any_enable) else $error("flag not set"); // R1

  property p_global_block;
    !core_reg[B_GLOBAL_EN] |=> !cpu_irq;
  endproperty
  a_global_block: assert property (p_global_block) else $error("irq while global off"); // R3

  property p_peri_block;
    (!core_reg[B_PERI_EN] && !core_pend) |=> !cpu_irq;
  endproperty
  a_peri_block: assert property (p_peri_block) else $error("peripheral irq leaked"); // R4

  property p_t0_sticky;
    (core_reg[B_T0_FLAG] && !wr_stb) |=> core_reg[B_T0_FLAG] [*1];
  endproperty
  a_t0_sticky: assert property (p_t0_sticky) else $error("timer-0 flag lost"); // R5

  property p_ext_edge;
    (ext_edge_rising && ext_irq_pin && !$past(ext_irq_pin) && primed_reg) |=> core_reg[B_EXT_FLAG];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("edge flag missed"); // R7

  property p_pin_change;
    pin_chg |=> core_reg[B_PCHG_FLAG];
  endproperty
  a_pin_change: assert property (p_pin_change) else $error("pin change missed"); // R8

  property p_peri1_zero;
    (rd_stb && hit(addr, OFF_PERI_EN1)) |=> (rd_data[5:4] == 2'b00);
  endproperty
  a_peri1_zero: assert property (p_peri1_zero) else $error("unused bits read one"); // R9

  property p_cmp_change;
    (comparator_one_output != $past(comparator_one_output) && primed_reg)
      |=> peri_fl2_reg[B_CMP1];
  endproperty
  a_cmp_change: assert property (p_cmp_change) else $error("comparator flag missed"); // R16

  property p_ccp_pwm;
    (capture_compare_pwm_mode && !peri_fl2_reg[B_CCP] && !wr_stb) |=> !peri_fl2_reg[B_CCP];
  endproperty
  a_ccp_pwm: assert property (p_ccp_pwm) else $error("ccp flag set in pwm"); // R18

  property p_bor_clear;
    brownout_reset_event |=> !pwr_reg[B_BOR];
  endproperty
  a_bor_clear: assert property (p_bor_clear) else $error("brown-out status kept"); // R20

  property p_irq_follow;
    irq_cond |=> cpu_irq ##1 (cpu_irq == $past(irq_cond));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not raised"); // R22

  c_core_irq: cover property (core_reg[B_GLOBAL_EN] && core_pend ##1 cpu_irq);
  c_peri_irq: cover property (peri_pend && !core_pend ##1 cpu_irq);
  c_set_over_clear: cover property (wr_stb && hit(addr, OFF_PERI_FL1) && |peri1_set);
  c_brownout: cover property (brownout_reset_event);

endmodule

// ===== testbench/ifrs_periph_model.sv
/*
  ifrs_periph_model: behavioural event sources standing beside the
  interrupt flag block (timers, adc, comparators, output generator,
  capture/compare and brown-out detector).
  assumes: fire_stb/fire_sel change just after a rising sys_clk edge;
  each fired source gives one single-cycle pulse, comparators toggle.
*/
module ifrs_periph_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       fire_stb,
  input  wire logic [3:0] fire_sel,
  output logic            timer_zero_rollover,
  output logic            timer_one_gate_event,
  output logic            adc_done_event,
  output logic            limit_timer_one_match,
  output logic            limit_timer_two_match,
  output logic            timer_two_match,
  output logic            timer_one_rollover,
  output logic            output_generator_shutdown,
  output logic            capture_compare_event,
  output logic            brownout_reset_event,
  output logic            comparator_one_output,
  output logic            comparator_two_output
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // event generation
  // ----------------------------------------------------------------
  logic [11:0] evt_reg;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_reg <= 12'h000;
    end else begin
      evt_reg[9:0] <= fire_stb ? (10'h001 << fire_sel) : 10'h000;
      if (fire_stb && fire_sel == 4'ha) begin
        evt_reg[10] <= ~evt_reg[10];
      end
      if (fire_stb && fire_sel == 4'hb) begin
        evt_reg[11] <= ~evt_reg[11];
      end
    end
  end

  assign timer_zero_rollover       = evt_reg[0];
  assign timer_one_gate_event      = evt_reg[1];
  assign adc_done_event            = evt_reg[2];
  assign limit_timer_one_match     = evt_reg[3];
  assign limit_timer_two_match     = evt_reg[4];
  assign timer_two_match           = evt_reg[5];
  assign timer_one_rollover        = evt_reg[6];
  assign output_generator_shutdown = evt_reg[7];
  assign capture_compare_event     = evt_reg[8];
  assign brownout_reset_event      = evt_reg[9];
  assign comparator_one_output     = evt_reg[10];
  assign comparator_two_output     = evt_reg[11];
endmodule

// ===== testbench/interrupt_flag_enable_and_reset_status_tb.sv
/*
  interrupt_flag_enable_and_reset_status_tb: self-checking bench of ifrs_top.
  assumes: 10 MHz sys_clk, register port with one-cycle read latency,
  event sources from ifrs_periph_model.
*/
module interrupt_flag_enable_and_reset_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ifrs_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       arst_n, wr_stb, rd_stb, ext_irq_pin, ext_edge_rising, pwm_mode;
  logic       fire_stb, cpu_irq, brownout_enable;
  logic [7:0] addr, wr_data, rd_data, c, e1, f1, e2, f2;
  logic [5:0] pins;
  logic [3:0] fire_sel;
  wire  [11:0] ev;
  logic [31:0] seed = 32'd70;
  int         fails = 0;
  int         comparisons = 0;
  logic [7:0] loc_off [12] = '{8'h00, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
                               8'h04, 8'h04, 8'h05, 8'h04, 8'h04};
  logic [7:0] loc_bit [12] = '{8'h04, 8'h80, 8'h40, 8'h04, 8'h08, 8'h02, 8'h01,
                               8'h04, 8'h01, 8'h00, 8'h10, 8'h20};

  always #50 sys_clk = ~sys_clk;

  ifrs_top #(.PIN_CNT(6)) ifrs_top_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .timer_zero_rollover(ev[0]), .ext_irq_pin(ext_irq_pin),
    .ext_edge_rising(ext_edge_rising), .pin_change_pins(pins),
    .timer_one_gate_event(ev[1]), .adc_done_event(ev[2]),
    .limit_timer_one_match(ev[3]), .limit_timer_two_match(ev[4]),
    .timer_two_match(ev[5]), .timer_one_rollover(ev[6]),
    .comparator_one_output(ev[10]), .comparator_two_output(ev[11]),
    .output_generator_shutdown(ev[7]), .capture_compare_event(ev[8]),
    .capture_compare_pwm_mode(pwm_mode), .brownout_reset_event(ev[9]),
    .cpu_irq(cpu_irq), .brownout_enable(brownout_enable));

  ifrs_periph_model ifrs_periph_model_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .fire_stb(fire_stb), .fire_sel(fire_sel),
    .timer_zero_rollover(ev[0]), .timer_one_gate_event(ev[1]),
    .adc_done_event(ev[2]), .limit_timer_one_match(ev[3]),
    .limit_timer_two_match(ev[4]), .timer_two_match(ev[5]),
    .timer_one_rollover(ev[6]), .output_generator_shutdown(ev[7]),
    .capture_compare_event(ev[8]), .brownout_reset_event(ev[9]),
    .comparator_one_output(ev[10]), .comparator_two_output(ev[11]));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic exp_irq(input logic [7:0] cc, a1, b1, a2, b2);
    return cc[7] & ((|(cc[5:3] & cc[2:0])) |
                    (cc[6] & (|((a1 & b1 & 8'hcf) | (a2 & b2 & 8'h35)))));
  endfunction

  task automatic tally_and_finish();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= v;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk(name, rd_data, exp);
  endtask

  task automatic fire(input int s);
    @(posedge sys_clk);
    fire_stb <= 1'b1;
    fire_sel <= s[3:0];
    @(posedge sys_clk);
    fire_stb <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0; addr = 8'h00; wr_data = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
    ext_irq_pin = 1'b0; ext_edge_rising = 1'b1; pins = 6'h00; pwm_mode = 1'b0;
    fire_stb = 1'b0; fire_sel = 4'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      rchk("reset value", i[7:0], (i == 5) ? 8'h01 : 8'h00);
    end
    chk("bor enable", {7'h0, brownout_enable}, 8'h00);
    wr(8'h01, 8'hff); rchk("peri en1", 8'h01, 8'hcf);
    wr(8'h02, 8'hff); rchk("peri en2", 8'h02, 8'h35);
    wr(8'h05, 8'hff); rchk("pwr stat", 8'h05, 8'h03);
    wr(8'h07, 8'hff); rchk("bor ctrl", 8'h07, 8'h01);
    chk("bor enable", {7'h0, brownout_enable}, 8'h01);
    wr(8'h08, 8'hff); rchk("unmapped", 8'h08, 8'h00);
    wr(8'h01, 8'h00); wr(8'h02, 8'h00); wr(8'h07, 8'h00);
    // each source but brown-out sets its flag with every enable off
    for (int s = 0; s < 12; s++) begin
      if (s != 9) begin
        fire(s);
        rchk("src flag", loc_off[s], loc_bit[s]);
        chk("irq masked", {7'h0, cpu_irq}, 8'h00);
        wr(loc_off[s], 8'h00);
      end
    end
    fire(10); rchk("cmp1 fall", 8'h04, 8'h10); wr(8'h04, 8'h00);
    // software clears stale flags before enabling, flag holds
    wr(8'h00, 8'ha0); fire(0); repeat (8) @(posedge sys_clk);
    rchk("t0 hold", 8'h00, 8'ha4);
    chk("t0 irq", {7'h0, cpu_irq}, 8'h01);
    wr(8'h00, 8'ha0); repeat (3) @(posedge sys_clk);
    #1 chk("t0 irq clr", {7'h0, cpu_irq}, 8'h00);
    wr(8'h00, 8'h00);
    // external pin, both edge selections
    for (int p = 0; p < 2; p++) begin
      ext_edge_rising <= p[0];
      for (int j = 0; j < 2; j++) begin
        @(posedge sys_clk); ext_irq_pin <= ~j[0];
        repeat (3) @(posedge sys_clk);
        rchk("ext edge", 8'h00, (p[0] ^ j[0]) ? 8'h02 : 8'h00);
        wr(8'h00, 8'h00);
      end
    end
    // pin change, only enabled pins
    wr(8'h06, 8'h01);
    @(posedge sys_clk); pins <= 6'h02; repeat (3) @(posedge sys_clk);
    rchk("pchg off", 8'h00, 8'h00);
    @(posedge sys_clk); pins <= 6'h03; repeat (3) @(posedge sys_clk);
    rchk("pchg on", 8'h00, 8'h01);
    wr(8'h00, 8'h00);
    // capture/compare ignored in pwm mode
    @(posedge sys_clk); pwm_mode <= 1'b1;
    fire(8); rchk("ccp pwm", 8'h04, 8'h00);
    @(posedge sys_clk); pwm_mode <= 1'b0;
    // brown-out clears its status, software sets it again
    fire(9); rchk("bor event", 8'h05, 8'h02);
    wr(8'h05, 8'h03); rchk("pwr set", 8'h05, 8'h03);
    // random enable and flag mixes
    repeat (40) begin
      seed = next_rand(seed); c = seed[7:0]; e1 = seed[15:8]; f1 = seed[23:16];
      e2 = seed[31:24]; seed = next_rand(seed); f2 = seed[7:0];
      wr(8'h01, e1); wr(8'h02, e2); wr(8'h03, f1); wr(8'h04, f2); wr(8'h00, c);
      repeat (3) @(posedge sys_clk);
      #1 chk("irq mix", {7'h0, cpu_irq}, {7'h0, exp_irq(c, e1, f1, e2, f2)});
      rchk("flags2", 8'h04, f2 & 8'h35);
    end
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end
endmodule
